// ==== hdl/rlip_cnt.v ====
// Purpose: saturating violation counter
// Assumes: inc and clr on the same clock
// Notes:   clear with increment in the same cycle loads one
module rlip_cnt #(
   parameter W = 16
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // control
   input wire inc,
   input wire clr,
   // result
   output reg [W-1:0] count,
   output reg sat_pulse
);

   wire at_max;

   assign at_max = &count;

   // count, clear, saturate at all ones
   always @(posedge clk) begin
      if (rst) begin
         count <= {W{1'b0}};
         sat_pulse <= 1'b0;
      end else begin
         sat_pulse <= 1'b0;
         if (clr && inc) begin
            count <= {{(W-1){1'b0}}, 1'b1};
         end else if (clr) begin
            count <= {W{1'b0}};
         end else if (inc && !at_max) begin
            count <= count + {{(W-1){1'b0}}, 1'b1};
            if (count == {{(W-1){1'b1}}, 1'b0}) begin
               sat_pulse <= 1'b1;
            end
         end
      end
   end

endmodule

// ==== hdl/rlip_consts.vh ====
// Purpose: shared constants of the receive line input port
// Assumes: included by bare name from the design files
// Notes:   register indices are word indices, byte address is four times
`ifndef RLIP_CONSTS_VH
`define RLIP_CONSTS_VH

// register word indices
`define RLIP_IDX_CTRL 3'h0
`define RLIP_IDX_STAT 3'h1
`define RLIP_IDX_IRQ_STAT 3'h2
`define RLIP_IDX_IRQ_MASK 3'h3
`define RLIP_IDX_VCOUNT 3'h4

// control fields
`define RLIP_CTRL_LIU_EN 0
`define RLIP_CTRL_SINGLE 1
`define RLIP_CTRL_CLK_SEL 2
`define RLIP_CTRL_CLK_INV 3
`define RLIP_CTRL_POS_INV 4
`define RLIP_CTRL_W 5
`define RLIP_CTRL_RST 5'h00

// status fields
`define RLIP_STAT_LAST_POS 0
`define RLIP_STAT_LAST_NEG 1
`define RLIP_STAT_CLK_OK 2
`define RLIP_STAT_W 3

// interrupt event fields
`define RLIP_EV_VIOL 0
`define RLIP_EV_SAT 1
`define RLIP_EV_BOTH 2
`define RLIP_EV_CLK_LOSS 3
`define RLIP_EV_W 4
`define RLIP_EV_RST 4'h0

// reference clock missing timeout
`define RLIP_CLK_PERIOD_NS 10
`define RLIP_LOSS_TIME_NS 640
`define RLIP_LOSS_CYCLES (`RLIP_LOSS_TIME_NS / `RLIP_CLK_PERIOD_NS)

`endif

// ==== hdl/rlip_sync.v ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes:   output follows once stages two and three agree
module rlip_sync #(
   parameter W = 4
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // async in, filtered out
   input wire [W-1:0] din,
   output reg [W-1:0] dout
);

   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   integer i;

   // shift chain, first stage feeds only the second
   always @(posedge clk) begin
      if (rst) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // accept a bit only where stages two and three agree
   always @(posedge clk) begin
      if (rst) begin
         dout <= {W{1'b0}};
      end else begin
         for (i = 0; i < W; i = i + 1) begin
            if (s2_r[i] == s3_r[i]) begin
               dout[i] <= s3_r[i];
            end
         end
      end
   end

endmodule

// ==== hdl/rlip_top.v ====
// Purpose: receive line input port, external or internal line interface
// Assumes: Avalon-MM slave, word addressed, line pins async to SYS_CLK
// Notes:   line clock is oversampled, edges found on SYS_CLK
//
// Contract
// RQ1 - In a bipolar mode with the internal unit off, a high positive rail means a positive pulse in that bit period.
// RQ2 - In a bipolar mode with the internal unit off, a high negative rail means a negative pulse in that bit period.
// RQ3 - Line inputs are sampled on the rising reference edge, or the falling edge when the reference is inverted.
// RQ4 - The reference is the line clock input by default and can be switched to the recovered clock output.
// RQ5 - The positive rail or data input has a selectable polarity inversion applied before interpretation.
// RQ6 - In single-rail mode the positive rail carries undecoded data, one bit per reference clock.
// RQ7 - In single-rail mode the violation counter increments once per sampling clock with the violation input high.
// RQ8 - With the internal unit enabled the line clock input is ignored and data comes from the internal unit.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`include "rlip_consts.vh"

module rlip_top #(
   parameter CNT_W = 16,
   parameter LOSS_CYCLES = `RLIP_LOSS_CYCLES
) (
   // clock and reset
   input wire SYS_CLK,
   input wire RESET,
   // avalon-mm slave
   input wire [2:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output reg [31:0] AVS_READDATA,
   output wire AVS_WAITREQUEST,
   // interrupt
   output wire IRQ,
   // external line interface pins
   input wire RX_LINE_CLOCK_IN,
   input wire RX_POSITIVE_RAIL,
   input wire RX_NEGATIVE_RAIL,
   // recovered clock from clock recovery, and its pin
   input wire RX_RECOVERED_CLOCK,
   output reg RX_RECOVERED_CLOCK_OUT,
   // internal line interface unit, same clock domain
   input wire LIU_RX_POS,
   input wire LIU_RX_NEG,
   input wire LIU_RX_STROBE,
   // received bits toward the decoder
   output reg RX_BIT_VALID,
   output reg RX_BIT_POS,
   output reg RX_BIT_NEG,
   output reg RX_BIT_SINGLE
);

   // control and status storage
   reg [`RLIP_CTRL_W-1:0] ctrl_r;
   reg [`RLIP_EV_W-1:0] irq_stat_r;
   reg [`RLIP_EV_W-1:0] irq_stat_nxt;
   reg [`RLIP_EV_W-1:0] irq_mask_r;
   reg ack_r;
   reg last_pos_r;
   reg last_neg_r;
   reg ref_prev_r;
   reg clk_ok_r;
   reg [15:0] idle_cnt_r;
   reg loss_pulse_r;

   wire liu_en;
   wire single_mode;
   wire clk_sel;
   wire clk_inv;
   wire pos_inv;
   wire [3:0] sync_out;
   wire s_lclk;
   wire s_rclk;
   wire s_pos;
   wire s_neg;
   wire ref_lvl;
   wire ref_edge;
   wire take;
   wire bit_pos;
   wire bit_neg;
   wire viol_inc;
   wire both_ev;
   wire [CNT_W-1:0] vcount;
   wire sat_pulse;
   wire wr_hit;
   wire rd_go;
   wire cnt_clr;
   wire [`RLIP_EV_W-1:0] ev_set;
   wire [15:0] loss_lim;

   // read data mux, unmapped reads zero
   function [31:0] rd_mux;
      input [2:0] idx;
      input [`RLIP_CTRL_W-1:0] c;
      input [`RLIP_STAT_W-1:0] s;
      input [`RLIP_EV_W-1:0] st;
      input [`RLIP_EV_W-1:0] mk;
      input [CNT_W-1:0] vc;
      begin
         rd_mux = 32'h0000_0000;
         case (idx)
            `RLIP_IDX_CTRL: rd_mux[`RLIP_CTRL_W-1:0] = c;
            `RLIP_IDX_STAT: rd_mux[`RLIP_STAT_W-1:0] = s;
            `RLIP_IDX_IRQ_STAT: rd_mux[`RLIP_EV_W-1:0] = st;
            `RLIP_IDX_IRQ_MASK: rd_mux[`RLIP_EV_W-1:0] = mk;
            `RLIP_IDX_VCOUNT: rd_mux[CNT_W-1:0] = vc;
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   endfunction

   // write strobe for one register index
   function wr_sel;
      input [2:0] idx;
      input [2:0] want;
      input go;
      input be0;
      begin
         wr_sel = go && be0 && (idx == want);
      end
   endfunction

   // control field aliases
   assign liu_en = ctrl_r[`RLIP_CTRL_LIU_EN];
   assign single_mode = ctrl_r[`RLIP_CTRL_SINGLE];
   assign clk_sel = ctrl_r[`RLIP_CTRL_CLK_SEL];
   assign clk_inv = ctrl_r[`RLIP_CTRL_CLK_INV];
   assign pos_inv = ctrl_r[`RLIP_CTRL_POS_INV];

   // bus handshake: one wait cycle, then the access completes
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_r;
   assign wr_hit = AVS_WRITE && ack_r;
   assign rd_go = AVS_READ && !ack_r;

   // acknowledge toggles for one cycle per access
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         ack_r <= 1'b0;
      end else if (ack_r) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= AVS_READ || AVS_WRITE;
      end
   end

   // read data captured in the wait cycle, stands while ack is high
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (rd_go) begin
         AVS_READDATA <= rd_mux(AVS_ADDRESS, ctrl_r, {clk_ok_r, last_neg_r, last_pos_r},
                                irq_stat_r, irq_mask_r, vcount);
      end
   end

   // control and mask registers
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         ctrl_r <= `RLIP_CTRL_RST;
         irq_mask_r <= `RLIP_EV_RST;
      end else begin
         if (wr_sel(AVS_ADDRESS, `RLIP_IDX_CTRL, wr_hit, AVS_BYTEENABLE[0])) begin
            ctrl_r <= AVS_WRITEDATA[`RLIP_CTRL_W-1:0];
         end
         if (wr_sel(AVS_ADDRESS, `RLIP_IDX_IRQ_MASK, wr_hit, AVS_BYTEENABLE[0])) begin
            irq_mask_r <= AVS_WRITEDATA[`RLIP_EV_W-1:0];
         end
      end
   end

   // a write to the counter word with byte lane 0 enabled clears it
   assign cnt_clr = wr_sel(AVS_ADDRESS, `RLIP_IDX_VCOUNT, wr_hit, AVS_BYTEENABLE[0]);

   // synchronise the four asynchronous line pins
   rlip_sync #(
      .W(4)
   ) u_sync (
      .clk(SYS_CLK),
      .rst(RESET),
      .din({RX_RECOVERED_CLOCK, RX_LINE_CLOCK_IN, RX_NEGATIVE_RAIL, RX_POSITIVE_RAIL}),
      .dout(sync_out)
   );

   assign s_pos = sync_out[0];
   assign s_neg = sync_out[1];
   assign s_lclk = sync_out[2];
   assign s_rclk = sync_out[3];

   // recovered clock pin driven from its filtered copy
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         RX_RECOVERED_CLOCK_OUT <= 1'b0;
      end else begin
         RX_RECOVERED_CLOCK_OUT <= s_rclk;
      end
   end

   // reference select, inversion handled at the edge detector
   assign ref_lvl = clk_sel ? s_rclk : s_lclk; // [RQ4]

   // history of the raw selected reference
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         ref_prev_r <= 1'b0;
      end else begin
         ref_prev_r <= ref_lvl;
      end
   end

   // rising or falling edge; flipping the invert bit alone makes no false edge
   assign ref_edge = clk_inv ? (!ref_lvl && ref_prev_r) : (ref_lvl && !ref_prev_r); // [RQ3]

   // source select: internal unit ignores the line clock entirely
   assign take = liu_en ? LIU_RX_STROBE : ref_edge; // [RQ8]
   assign bit_pos = liu_en ? LIU_RX_POS : (s_pos ^ pos_inv); // [RQ5] [RQ8]
   assign bit_neg = liu_en ? LIU_RX_NEG : s_neg;

   // pulse marks: positive and negative rails per bit period
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         RX_BIT_VALID <= 1'b0;
         RX_BIT_POS <= 1'b0;
         RX_BIT_NEG <= 1'b0;
         RX_BIT_SINGLE <= 1'b0;
      end else begin
         RX_BIT_VALID <= take;
         if (take) begin
            RX_BIT_POS <= bit_pos; // [RQ1] [RQ6]
            RX_BIT_NEG <= single_mode ? 1'b0 : bit_neg; // [RQ2]
            RX_BIT_SINGLE <= single_mode; // [RQ6]
         end
      end
   end

   // last sampled rail values for status
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         last_pos_r <= 1'b0;
         last_neg_r <= 1'b0;
      end else if (take) begin
         last_pos_r <= bit_pos;
         last_neg_r <= bit_neg;
      end
   end

   // violation flag counts once per sampling clock in single-rail mode
   assign viol_inc = take && single_mode && bit_neg; // [RQ7]

   // both rails high in a bipolar bit period is not a valid symbol
   assign both_ev = take && !single_mode && bit_pos && bit_neg;

   rlip_cnt #(
      .W(CNT_W)
   ) u_cnt (
      .clk(SYS_CLK),
      .rst(RESET),
      .inc(viol_inc),
      .clr(cnt_clr),
      .count(vcount),
      .sat_pulse(sat_pulse)
   );

   // reference clock activity watchdog, limit cut to the counter width
   localparam [31:0] LOSS_LIM_W = LOSS_CYCLES;
   assign loss_lim = LOSS_LIM_W[15:0];

   always @(posedge SYS_CLK) begin
      if (RESET) begin
         idle_cnt_r <= 16'h0000;
         clk_ok_r <= 1'b0;
         loss_pulse_r <= 1'b0;
      end else begin
         loss_pulse_r <= 1'b0;
         if (take) begin
            idle_cnt_r <= 16'h0000;
            clk_ok_r <= 1'b1;
         end else if (idle_cnt_r < loss_lim) begin
            idle_cnt_r <= idle_cnt_r + 16'h0001;
         end else if (clk_ok_r) begin
            clk_ok_r <= 1'b0;
            loss_pulse_r <= 1'b1;
         end
      end
   end

   // sticky events, set wins over write-one clear
   assign ev_set = {loss_pulse_r, both_ev, sat_pulse, viol_inc};

   always @* begin
      irq_stat_nxt = irq_stat_r;
      if (wr_sel(AVS_ADDRESS, `RLIP_IDX_IRQ_STAT, wr_hit, AVS_BYTEENABLE[0])) begin
         irq_stat_nxt = irq_stat_r & ~AVS_WRITEDATA[`RLIP_EV_W-1:0];
      end
      irq_stat_nxt = irq_stat_nxt | ev_set;
   end

   always @(posedge SYS_CLK) begin
      if (RESET) begin
         irq_stat_r <= `RLIP_EV_RST;
      end else begin
         irq_stat_r <= irq_stat_nxt;
      end
   end

   // level interrupt while an unmasked event is pending
   assign IRQ = |(irq_stat_r & irq_mask_r);

endmodule

// ==== sim/rlip_line_model.sv ====
// Purpose: external line unit model
// Assumes: clocks stand low between frames
// Notes: data changes a quarter bit before each rising edge
module rlip_line_model (
   // line pins
   output logic line_clk,
   output logic rec_clk,
   output logic pos,
   output logic neg
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle levels
   initial begin
      line_clk = 1'b0;
      rec_clk = 1'b0;
      pos = 1'b0;
      neg = 1'b0;
   end
   // one frame, lsb first, on line or recovered clock
   task send(input [7:0] p, input [7:0] n, input rec);
      // step off the system clock edge before the first change
      #2;
      for (int i = 0; i < 8; i++) begin
         pos = p[i];
         neg = n[i];
         #31.25;
         if (rec) rec_clk = 1'b1;
         else line_clk = 1'b1;
         #62.5;
         rec_clk = 1'b0;
         line_clk = 1'b0;
         #31.25;
      end
      pos = ~p[7];
      neg = ~n[7];
   endtask
endmodule

// ==== sim/rlip_properties.sv ====
// Purpose: port checker for the receive line input port
// Assumes: control word shadowed from accepted bus writes
// Notes: bound to rlip_top
module rlip_properties (
   // clock and reset
   input wire SYS_CLK,
   input wire RESET,
   // bus and interrupt
   input wire [2:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   input wire AVS_WAITREQUEST,
   input wire IRQ,
   // line side
   input wire RX_LINE_CLOCK_IN,
   input wire RX_RECOVERED_CLOCK,
   input wire RX_RECOVERED_CLOCK_OUT,
   input wire LIU_RX_POS,
   input wire LIU_RX_NEG,
   input wire LIU_RX_STROBE,
   input wire RX_BIT_VALID,
   input wire RX_BIT_POS,
   input wire RX_BIT_NEG,
   input wire RX_BIT_SINGLE
);
   timeunit 1ns;
   timeprecision 100ps;
   reg [4:0] ctrl_r;
   reg [3:0] age_r;
   wire wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
   wire lin = !ctrl_r[0] && !ctrl_r[2];
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   // shadow control word, age of internal unit selection
   always @(posedge SYS_CLK) begin
      if (RESET) ctrl_r <= 5'h00;
      else if (wr_ok && AVS_ADDRESS == 3'h0) ctrl_r <= AVS_WRITEDATA[4:0];
      if (RESET || !ctrl_r[0]) age_r <= 4'h0;
      else if (age_r != 4'hf) age_r <= age_r + 4'h1;
   end
   property p_wait_one;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
   property p_rise;
      $rose(RX_LINE_CLOCK_IN) && lin && !ctrl_r[3] |-> ##[3:6] RX_BIT_VALID;
   endproperty
   a_rise: assert property (p_rise) else $error("no bit after rising edge");
   property p_fall;
      $fell(RX_LINE_CLOCK_IN) && lin && ctrl_r[3] |-> ##[3:6] RX_BIT_VALID;
   endproperty
   a_fall: assert property (p_fall) else $error("no bit after falling edge");
   property p_rec;
      $rose(RX_RECOVERED_CLOCK) && !ctrl_r[0] && ctrl_r[2] && !ctrl_r[3] |-> ##[3:8] RX_BIT_VALID;
   endproperty
   a_rec: assert property (p_rec) else $error("no bit on recovered clock");
   property p_rec_out;
      $rose(RX_RECOVERED_CLOCK) |-> ##[1:6] RX_RECOVERED_CLOCK_OUT;
   endproperty
   a_rec_out: assert property (p_rec_out) else $error("recovered copy stuck");
   property p_liu;
      ctrl_r[0] && !ctrl_r[1] && LIU_RX_STROBE |=>
         RX_BIT_VALID && RX_BIT_POS == $past(LIU_RX_POS) && RX_BIT_NEG == $past(LIU_RX_NEG);
   endproperty
   a_liu: assert property (p_liu) else $error("internal bit lost");
   property p_liu_quiet;
      age_r == 4'hf && !$past(LIU_RX_STROBE) |-> !RX_BIT_VALID;
   endproperty
   a_liu_quiet: assert property (p_liu_quiet) else $error("line bit with unit on");
   property p_single;
      RX_BIT_VALID && RX_BIT_SINGLE |-> !RX_BIT_NEG;
   endproperty
   a_single: assert property (p_single) else $error("negative rail in single mode");
   property p_irq_off;
      wr_ok && AVS_ADDRESS == 3'h3 && AVS_WRITEDATA[3:0] == 4'h0 |=> !IRQ;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq with zero mask");
   // main scenarios
   c_single: cover property (RX_BIT_VALID && RX_BIT_SINGLE);
   c_irq: cover property (IRQ);
   c_liu: cover property (ctrl_r[0] && RX_BIT_VALID);
endmodule
bind rlip_top rlip_properties rlip_properties_inst (.SYS_CLK(SYS_CLK), .RESET(RESET),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
   .RX_LINE_CLOCK_IN(RX_LINE_CLOCK_IN), .RX_RECOVERED_CLOCK(RX_RECOVERED_CLOCK),
   .RX_RECOVERED_CLOCK_OUT(RX_RECOVERED_CLOCK_OUT), .LIU_RX_POS(LIU_RX_POS), .LIU_RX_NEG(LIU_RX_NEG),
   .LIU_RX_STROBE(LIU_RX_STROBE), .RX_BIT_VALID(RX_BIT_VALID), .RX_BIT_POS(RX_BIT_POS),
   .RX_BIT_NEG(RX_BIT_NEG), .RX_BIT_SINGLE(RX_BIT_SINGLE));

// ==== sim/rlip_top_bench.sv ====
// Purpose: bench for the receive line input port
// Assumes: model drives the line pins
// Notes: bus tasks wait on waitrequest
module rlip_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, lstb = 1'b0, lpos = 1'b0, lneg = 1'b0;
   logic [2:0] adr = 3'h0;
   logic [31:0] wdat = 32'h0, rd_v;
   wire [31:0] rx_single_rail_data;
   wire wreq, irq, lclk, rclk, rx_positive_rail, rx_negative_rail, vld, bpos, bneg, bsgl;
   logic [2:0] got_q[$];
   int n_errors = 0, n_checks = 0;
   rlip_top rlip_top_inst (.SYS_CLK(clk), .RESET(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rx_single_rail_data), .AVS_WAITREQUEST(wreq), .IRQ(irq),
      .RX_LINE_CLOCK_IN(lclk), .RX_POSITIVE_RAIL(rx_positive_rail), .RX_NEGATIVE_RAIL(rx_negative_rail), .RX_RECOVERED_CLOCK(rclk),
      .RX_RECOVERED_CLOCK_OUT(), .LIU_RX_POS(lpos), .LIU_RX_NEG(lneg), .LIU_RX_STROBE(lstb),
      .RX_BIT_VALID(vld), .RX_BIT_POS(bpos), .RX_BIT_NEG(bneg), .RX_BIT_SINGLE(bsgl));
   rlip_line_model rlip_line_model_inst (.line_clk(lclk), .rec_clk(rclk), .pos(rx_positive_rail), .neg(rx_negative_rail));
   // clock and received bit log
   always #5 clk = ~clk;
   always @(posedge clk) if (vld === 1'b1) got_q.push_back({bpos, bneg, bsgl});
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one bus access, held until waitrequest is seen low
   task bus(input w, input [2:0] a, input [31:0] d);
      @(posedge clk);
      adr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      do @(posedge clk); while (wreq !== 1'b0);
      rd_v = rx_single_rail_data;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task rdc(input string nm, input [2:0] a, input [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd_v);
   endtask
   // send a frame and compare the logged bits
   task frame(input [7:0] p, input [7:0] n, input rec, input [7:0] ep, input [7:0] en, input s, input int cnt);
      repeat (10) @(posedge clk);
      got_q.delete();
      rlip_line_model_inst.send(p, n, rec);
      repeat (10) @(posedge clk);
      chk("bit count", cnt, got_q.size());
      for (int i = 0; i < cnt; i++) chk("bit", {ep[i], en[i], s}, got_q[i]);
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #100000;
      n_errors++;
      give_verdict;
   end
   // test sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      bus(1'b1, 3'h6, 32'hffffffff);
      for (int a = 0; a < 8; a++) rdc("reset value", a[2:0], 32'h0);
      $display("test registers done");
      frame(8'hc5, 8'h32, 1'b0, 8'hc5, 8'h32, 1'b0, 8);
      bus(1'b1, 3'h0, 32'h18);
      frame(8'hc5, 8'h32, 1'b0, 8'h3a, 8'h32, 1'b0, 8);
      $display("test bipolar done");
      bus(1'b1, 3'h0, 32'h4);
      frame(8'h96, 8'h41, 1'b1, 8'h96, 8'h41, 1'b0, 8);
      frame(8'h0f, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 0);
      $display("test recovered clock done");
      bus(1'b1, 3'h3, 32'h1);
      bus(1'b1, 3'h0, 32'h2);
      bus(1'b1, 3'h4, 32'h0);
      frame(8'h5a, 8'h0b, 1'b0, 8'h5a, 8'h00, 1'b1, 8);
      rdc("status", 3'h1, 32'h4);
      rdc("violation count", 3'h4, 32'h3);
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b0, 3'h2, 32'h0);
      chk("event status", 32'hd, rd_v);
      bus(1'b1, 3'h3, 32'h0);
      @(posedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1'b1, 3'h3, 32'h1);
      bus(1'b1, 3'h2, 32'hf);
      @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test single rail done");
      bus(1'b1, 3'h0, 32'h1);
      frame(8'hff, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         lpos <= i[0];
         lneg <= i[1];
         lstb <= 1'b1;
         @(posedge clk);
         lstb <= 1'b0;
      end
      repeat (3) @(posedge clk);
      chk("unit count", 32'h4, got_q.size());
      for (int i = 0; i < 4; i++) chk("unit bit", {i[0], i[1], 1'b0}, got_q[i]);
      $display("test internal unit done");
      give_verdict;
   end
endmodule
